// ### hdl/irq_pkg.sv
// shared constants and types of the two-level interrupt controller
package irq_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFF_MAIN_CTRL = 8'h00;
	localparam logic [7:0] OFF_RESET_CTRL = 8'h04;
	localparam logic [7:0] OFF_CORE_FLAG = 8'h08;
	localparam logic [7:0] OFF_CORE_EN = 8'h0C;
	localparam logic [7:0] OFF_CORE_PRIO = 8'h10;
	localparam logic [7:0] OFF_EDGE_SEL = 8'h14;
	localparam logic [7:0] OFF_PER_FLAG = 8'h18;
	localparam logic [7:0] OFF_PER_EN = 8'h1C;
	localparam logic [7:0] OFF_PER_PRIO = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;
	// field positions
	localparam int BIT_GLOBAL_HIGH = 7;
	localparam int BIT_GLOBAL_LOW = 6;
	localparam int BIT_PRIO_EN = 7;
	localparam int BIT_ST_IN_HIGH = 0;
	localparam int BIT_ST_IN_LOW = 1;
	localparam int BIT_ST_BUSY = 2;
	// source counts; core source 4 is the port-change source
	localparam int EXT_N = 4;
	localparam int CORE_N = 5;
	localparam int PER_N = 8;
	// reset values
	localparam logic RST_GLOBAL = 1'b0;
	localparam logic RST_PRIO_EN = 1'b0;
	localparam logic [4:0] RST_CORE_PRIO = 5'h1F;
	localparam logic [3:0] RST_EDGE_SEL = 4'hF;
	localparam logic [7:0] RST_PER_PRIO = 8'hFF;
	// vectors
	localparam logic [15:0] VEC_HIGH = 16'h0008;
	localparam logic [15:0] VEC_LOW = 16'h0018;
	// latency in instruction cycles from flag set to vector load
	localparam int LATENCY_CYC = 3;
	localparam logic [1:0] LAT_CNT_INIT = 2'(LATENCY_CYC - 2);
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT} ctl_state_t;
endpackage

// ### hdl/irq_edge_catch.sv
// edge and change detection of the external interrupt pins and port pins
module irq_edge_catch (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// pins
	input wire logic [3:0] ext_pin,
	input wire logic [3:0] port_pin,
	input wire logic [3:0] ext_pin0_edge_select,
	// events, one-cycle pulses
	output logic [3:0] ext_evt,
	output logic port_evt
);
	typedef struct packed {
		logic primed;
		logic [3:0] pin_q;
		logic [3:0] port_q;
		logic [3:0] ext_evt;
		logic port_evt;
	} edge_state_t;

	edge_state_t s;
	edge_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.pin_q = ext_pin;
		next_s.port_q = port_pin;
		next_s.primed = 1'b1;
		// select 1 takes rising, 0 takes falling; no event until first sample is held
		next_s.ext_evt = {4{s.primed}} & (ext_pin ^ s.pin_q)
			& ~(ext_pin ^ ext_pin0_edge_select);
		next_s.port_evt = s.primed & (|(port_pin ^ s.port_q));
		if (sys_rst) begin
			next_s = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		s <= next_s;
	end

	assign ext_evt = s.ext_evt;
	assign port_evt = s.port_evt;
endmodule

// ### hdl/irq_arbiter.sv
// request qualification: global gating, compatibility mode and level choice
module irq_arbiter (
	// mode and global enables
	input wire logic priority_feature_enable,
	input wire logic global_high_irq_enable,
	input wire logic global_low_irq_enable,
	input wire logic in_high,
	// per-source bits
	input wire logic [4:0] core_flag,
	input wire logic [4:0] core_en,
	input wire logic [4:0] core_prio,
	input wire logic [7:0] per_flag,
	input wire logic [7:0] per_en,
	input wire logic [7:0] per_prio,
	// qualified requests
	output logic want_high,
	output logic want_low
);
	function automatic logic hit(input logic [7:0] f, input logic [7:0] e,
			input logic [7:0] p, input logic lvl);
		hit = |(f & e & (lvl ? p : ~p));
	endfunction

	logic core_any;
	logic per_any;
	logic hi_any;
	logic lo_any;

	always_comb begin
		core_any = |(core_flag & core_en);
		per_any = |(per_flag & per_en);
		hi_any = hit({3'h0, core_flag}, {3'h0, core_en}, {3'h0, core_prio}, 1'b1)
			| hit(per_flag, per_en, per_prio, 1'b1);
		lo_any = hit({3'h0, core_flag}, {3'h0, core_en}, {3'h0, core_prio}, 1'b0)
			| hit(per_flag, per_en, per_prio, 1'b0);
		if (priority_feature_enable) begin
			want_high = global_high_irq_enable & hi_any;
			// low level also needs the high enable, and never runs inside a high handler
			want_low = global_high_irq_enable & global_low_irq_enable & ~in_high
				& lo_any;
		end else begin
			// priority bits ignored; bit 6 gates the peripheral group
			want_high = global_high_irq_enable
				& (core_any | (global_low_irq_enable & per_any));
			want_low = 1'b0;
		end
	end
endmodule

// ### hdl/irq_ctrl_top.sv
// two-level prioritised interrupt controller with an AHB-Lite register slave
//
// Summary of operation
// - high level vectors to 0008h, low level vectors to 0018h
// - an eligible high request preempts a running low handler
// - every source owns a flag, an enable and a priority bit
// - priority operation only while the priority feature enable is set
// - in priority mode bit 7 gates all high-level sources
// - in priority mode bit 6 gates all low-level sources
// - flag, enable and global enable set vector by the priority bit
// - reset clears priority enable; priority bits then have no effect
// - compatibility mode: bit 6 gates peripherals, bit 7 gates all
// - compatibility mode vectors everything to 0008h
// - entry clears the global enable in use for the accepted level
// - no low entry while a high handler is in progress
// - entry pushes the return address and loads the vector
// - return from interrupt sets the enable cleared on entry
// - pin and port changes reach the vector five cycles after the change: two to set the flag, then three
// - flags set on events regardless of any enable
// - bit 6 gates low peripherals, or all peripherals without priority
// - each external pin has an edge select, 1 rising, 0 falling
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
module irq_ctrl_top (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// interrupt sources
	input wire logic [3:0] ext_pin,
	input wire logic [3:0] port_pin,
	input wire logic [7:0] periph_evt,
	// core side
	input wire logic return_from_irq_instr,
	input wire logic core_sleep,
	output logic pc_load,
	output logic stack_push,
	output logic [15:0] vector_addr,
	output logic wake_req
);
	typedef struct packed {
		irq_pkg::ctl_state_t state;
		logic [1:0] cnt;
		logic lvl_high;
		logic gh;
		logic gl;
		logic prio_on;
		logic [4:0] core_flag;
		logic [4:0] core_en;
		logic [4:0] core_prio;
		logic [3:0] edge_sel;
		logic [7:0] per_flag;
		logic [7:0] per_en;
		logic [7:0] per_prio;
		logic in_high;
		logic in_low;
		logic dp_valid;
		logic dp_write;
		logic [7:0] dp_addr;
		logic rdy;
		logic resp;
		logic [31:0] hrdata;
		logic pc_load;
		logic stack_push;
		logic [15:0] vector;
		logic wake_req;
	} top_state_t;

	top_state_t s;
	top_state_t next_s;
	logic [3:0] ext_evt;
	logic port_evt;
	logic want_high;
	logic want_low;
	logic addr_phase;

	irq_edge_catch u_edge (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.ext_pin(ext_pin),
		.port_pin(port_pin),
		.ext_pin0_edge_select(s.edge_sel),
		.ext_evt(ext_evt),
		.port_evt(port_evt)
	);

	irq_arbiter u_arb (
		.priority_feature_enable(s.prio_on),
		.global_high_irq_enable(s.gh),
		.global_low_irq_enable(s.gl),
		.in_high(s.in_high),
		.core_flag(s.core_flag),
		.core_en(s.core_en),
		.core_prio(s.core_prio),
		.per_flag(s.per_flag),
		.per_en(s.per_en),
		.per_prio(s.per_prio),
		.want_high(want_high),
		.want_low(want_low)
	);

	// read mux works on the updated state so a read right after a write sees it
	function automatic logic [31:0] read_reg(input logic [7:0] a, input top_state_t t);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case (a)
			irq_pkg::OFF_MAIN_CTRL: begin
				d[irq_pkg::BIT_GLOBAL_HIGH] = t.gh;
				d[irq_pkg::BIT_GLOBAL_LOW] = t.gl;
			end
			irq_pkg::OFF_RESET_CTRL: d[irq_pkg::BIT_PRIO_EN] = t.prio_on;
			irq_pkg::OFF_CORE_FLAG: d[4:0] = t.core_flag;
			irq_pkg::OFF_CORE_EN: d[4:0] = t.core_en;
			irq_pkg::OFF_CORE_PRIO: d[4:0] = t.core_prio;
			irq_pkg::OFF_EDGE_SEL: d[3:0] = t.edge_sel;
			irq_pkg::OFF_PER_FLAG: d[7:0] = t.per_flag;
			irq_pkg::OFF_PER_EN: d[7:0] = t.per_en;
			irq_pkg::OFF_PER_PRIO: d[7:0] = t.per_prio;
			irq_pkg::OFF_STATUS: begin
				d[irq_pkg::BIT_ST_IN_HIGH] = t.in_high;
				d[irq_pkg::BIT_ST_IN_LOW] = t.in_low;
				d[irq_pkg::BIT_ST_BUSY] = (t.state == irq_pkg::ST_WAIT);
			end
			default: d = 32'h0000_0000;
		endcase
		return d;
	endfunction

	always_comb begin
		next_s = s;
		next_s.pc_load = 1'b0;
		next_s.stack_push = 1'b0;
		addr_phase = hsel & hready & htrans[1];
		// data phase of a write
		if (s.dp_valid && s.dp_write) begin
			unique case (s.dp_addr)
				irq_pkg::OFF_MAIN_CTRL: begin
					next_s.gh = hwdata[irq_pkg::BIT_GLOBAL_HIGH];
					next_s.gl = hwdata[irq_pkg::BIT_GLOBAL_LOW];
				end
				irq_pkg::OFF_RESET_CTRL: next_s.prio_on = hwdata[irq_pkg::BIT_PRIO_EN];
				irq_pkg::OFF_CORE_FLAG: next_s.core_flag = hwdata[4:0];
				irq_pkg::OFF_CORE_EN: next_s.core_en = hwdata[4:0];
				irq_pkg::OFF_CORE_PRIO: next_s.core_prio = hwdata[4:0];
				irq_pkg::OFF_EDGE_SEL: next_s.edge_sel = hwdata[3:0];
				irq_pkg::OFF_PER_FLAG: next_s.per_flag = hwdata[7:0];
				irq_pkg::OFF_PER_EN: next_s.per_en = hwdata[7:0];
				irq_pkg::OFF_PER_PRIO: next_s.per_prio = hwdata[7:0];
				default: ;
			endcase
		end
		// events win over a clearing write in the same cycle
		next_s.core_flag = next_s.core_flag | {port_evt, ext_evt};
		next_s.per_flag = next_s.per_flag | periph_evt;
		// return from interrupt restores the enable of the level it leaves
		if (return_from_irq_instr) begin
			if (s.in_high || !s.in_low) begin
				next_s.in_high = 1'b0;
				next_s.gh = 1'b1;
			end else begin
				next_s.in_low = 1'b0;
				next_s.gl = 1'b1;
			end
		end
		unique case (s.state)
			irq_pkg::ST_IDLE: begin
				if (want_high || want_low) begin
					next_s.state = irq_pkg::ST_WAIT;
					next_s.cnt = irq_pkg::LAT_CNT_INIT;
					next_s.lvl_high = want_high;
				end
			end
			irq_pkg::ST_WAIT: begin
				// a committed entry is upgraded if the high level turns up meanwhile
				if (want_high) begin
					next_s.lvl_high = 1'b1;
				end
				if (s.cnt == 2'h0) begin
					next_s.state = irq_pkg::ST_IDLE;
					next_s.pc_load = 1'b1;
					next_s.stack_push = 1'b1;
					if (next_s.lvl_high || !s.prio_on) begin
						next_s.vector = irq_pkg::VEC_HIGH;
						next_s.gh = 1'b0;
						next_s.in_high = 1'b1;
					end else begin
						next_s.vector = irq_pkg::VEC_LOW;
						next_s.gl = 1'b0;
						next_s.in_low = 1'b1;
					end
				end else begin
					next_s.cnt = s.cnt - 2'h1;
				end
			end
			// unused encodings of the two-bit state fall back to idle
			default: begin
				next_s.state = irq_pkg::ST_IDLE;
			end
		endcase
		// wake ignores the global enables, like a polled source would
		next_s.wake_req = core_sleep & ((|(s.core_flag & s.core_en))
			| (|(s.per_flag & s.per_en)));
		// bus: zero wait states, always OKAY
		next_s.dp_valid = addr_phase;
		if (addr_phase) begin
			next_s.dp_write = hwrite;
			next_s.dp_addr = haddr[7:0];
			if (!hwrite) begin
				next_s.hrdata = read_reg(haddr[7:0], next_s);
			end
		end
		if (sys_rst) begin
			next_s = '0;
			next_s.state = irq_pkg::ST_IDLE;
			next_s.gh = irq_pkg::RST_GLOBAL;
			next_s.gl = irq_pkg::RST_GLOBAL;
			next_s.prio_on = irq_pkg::RST_PRIO_EN;
			next_s.core_prio = irq_pkg::RST_CORE_PRIO;
			next_s.edge_sel = irq_pkg::RST_EDGE_SEL;
			next_s.per_prio = irq_pkg::RST_PER_PRIO;
			next_s.rdy = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		s <= next_s;
	end

	assign hreadyout = s.rdy;
	assign hresp = s.resp;
	assign hrdata = s.hrdata;
	assign pc_load = s.pc_load;
	assign stack_push = s.stack_push;
	assign vector_addr = s.vector;
	assign wake_req = s.wake_req;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	a_high_vector:
	assert property (pc_load && s.in_high && !$past(s.in_high) |-> vector_addr == 16'h0008)
		else $error("high entry did not load 0008h");
	a_compat_vector:
	assert property (pc_load && !s.prio_on |-> vector_addr == 16'h0008)
		else $error("compatibility entry not at 0008h");
	a_entry_latency:
	assert property (s.state == irq_pkg::ST_IDLE && (want_high || want_low)
		|-> ##1 !pc_load ##1 !pc_load ##1 pc_load)
		else $error("vector not loaded three cycles after request");
	a_low_clears_gl:
	assert property (pc_load && vector_addr == 16'h0018 |-> !s.gl && s.in_low && stack_push)
		else $error("low entry left low enable set");
	a_high_clears_gh:
	assert property (pc_load && vector_addr == 16'h0008 |-> !s.gh && s.in_high && stack_push)
		else $error("high entry left high enable set");
	a_no_low_in_high:
	assert property (pc_load && vector_addr == 16'h0018 |-> !$past(s.in_high, 3))
		else $error("low entry during high handler");
	a_preempt_low:
	assert property (s.in_low && !s.in_high && want_high && s.state == irq_pkg::ST_IDLE
		|-> ##3 pc_load && vector_addr == 16'h0008)
		else $error("high request did not preempt low handler");
	a_return_restore:
	assert property (return_from_irq_instr && s.in_high && s.state == irq_pkg::ST_IDLE
		|=> s.gh && !s.in_high)
		else $error("return did not restore high enable");
	a_flag_sets:
	assert property (ext_evt[0] || port_evt |=> s.core_flag[0] || s.core_flag[4])
		else $error("event flag not set");
	a_wake_req:
	assert property (core_sleep && (|(s.core_flag & s.core_en)) |=> wake_req)
		else $error("sleeping core not woken");

	a_ext_flags:
	assert property ((|ext_evt) |=> (s.core_flag[3:0] & $past(ext_evt)) == $past(ext_evt))
		else $error("pin event did not set its flag");
	a_port_flag:
	assert property (port_evt |=> s.core_flag[4])
		else $error("port change did not set its flag");
	a_per_flags:
	assert property ((|periph_evt) |=> (s.per_flag & $past(periph_evt)) == $past(periph_evt))
		else $error("peripheral event did not set its flag");
	a_high_gated:
	assert property (!s.gh |-> !want_high && !want_low)
		else $error("request passed with bit 7 clear");
	a_compat_no_low:
	assert property (!s.prio_on |-> !want_low)
		else $error("low request in compatibility mode");

	c_high_entry: cover property (pc_load && vector_addr == 16'h0008 && s.prio_on);
	c_low_entry: cover property (pc_load && vector_addr == 16'h0018);
	c_preempt: cover property (pc_load && vector_addr == 16'h0008 && s.in_low);
	c_compat_entry: cover property (pc_load && !s.prio_on);
	c_port_change: cover property (port_evt);
endmodule

// ### tb/irq_core_model.sv
// behavioural core: takes vector loads, issues return-from-interrupt pulses
module irq_core_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// controller side
	input wire logic pc_load,
	input wire logic stack_push,
	input wire logic [15:0] vector_addr,
	output logic return_from_irq_instr,
	// bench side
	input wire logic ret_req,
	output int entries,
	output int faults
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			return_from_irq_instr <= 1'b0;
			entries <= 0;
			faults <= 0;
		end else begin
			// one-cycle pulse, one cycle behind the bench request
			return_from_irq_instr <= ret_req;
			if (pc_load === 1'b1) begin
				entries <= entries + 1;
			end
			// push must come with every load, and only then
			if (pc_load !== stack_push) begin
				faults <= faults + 1;
			end
			// only the two vectors exist
			if (pc_load === 1'b1 && vector_addr !== irq_pkg::VEC_HIGH
					&& vector_addr !== irq_pkg::VEC_LOW) begin
				faults <= faults + 1;
			end
		end
	end
endmodule

// ### tb/two_level_priority_interrupt_ctrl_tb_top.sv
// self-checking bench of the interrupt controller over AHB-Lite
module two_level_priority_interrupt_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp;
	logic [31:0] hrdata;
	logic [3:0] ext_pin = 4'h0;
	logic [3:0] port_pin = 4'h0;
	logic [7:0] periph_evt = 8'h00;
	logic ret_req = 1'b0;
	logic core_sleep = 1'b0;
	logic return_from_irq_instr, pc_load, stack_push, wake_req;
	logic [15:0] vector_addr;
	int entries, faults;
	int miscompares = 0;
	int checks = 0;
	logic [7:0] rst_addr [7] = '{irq_pkg::OFF_MAIN_CTRL, irq_pkg::OFF_RESET_CTRL,
		irq_pkg::OFF_CORE_PRIO, irq_pkg::OFF_EDGE_SEL, irq_pkg::OFF_PER_PRIO,
		irq_pkg::OFF_STATUS, 8'h30};
	logic [31:0] rst_val [7] = '{32'h0, 32'h0, {27'h0, irq_pkg::RST_CORE_PRIO},
		{28'h0, irq_pkg::RST_EDGE_SEL}, {24'h0, irq_pkg::RST_PER_PRIO}, 32'h0, 32'h0};
	always #50 clk_sys = ~clk_sys;
	irq_ctrl_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.ext_pin(ext_pin), .port_pin(port_pin), .periph_evt(periph_evt),
		.return_from_irq_instr(return_from_irq_instr), .core_sleep(core_sleep),
		.pc_load(pc_load), .stack_push(stack_push), .vector_addr(vector_addr),
		.wake_req(wake_req));
	irq_core_model core (.clk_sys(clk_sys), .sys_rst(sys_rst), .pc_load(pc_load),
		.stack_push(stack_push), .vector_addr(vector_addr),
		.return_from_irq_instr(return_from_irq_instr), .ret_req(ret_req),
		.entries(entries), .faults(faults));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_rdy();
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask
	task automatic pulse_periph();
		@(posedge clk_sys);
		periph_evt <= 8'h08;
		@(posedge clk_sys);
		periph_evt <= 8'h00;
	endtask
	// expects one load within a bounded wait; n_exp 0 skips the latency figure
	task automatic wait_entry(input logic [15:0] vec, input int n_exp);
		int n;
		n = 0;
		do begin
			n++;
			@(posedge clk_sys);
			#1;
		end while (pc_load !== 1'b1 && n < 20);
		chk({31'h0, stack_push}, 32'h1);
		chk({16'h0, vector_addr}, {16'h0, vec});
		if (n_exp != 0) chk(n, n_exp);
	endtask
	task automatic no_entry();
		int e;
		e = entries;
		repeat (10) @(posedge clk_sys);
		chk(entries, e);
	endtask
	task automatic do_ret();
		@(posedge clk_sys);
		ret_req <= 1'b1;
		@(posedge clk_sys);
		ret_req <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic close_out();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		close_out();
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		for (int i = 0; i < 7; i++) rd_chk(rst_addr[i], rst_val[i]);
		$display("test reset_values done");
		pulse_periph();
		rd_chk(irq_pkg::OFF_PER_FLAG, 32'h08);
		chk(entries, 0);
		wr(irq_pkg::OFF_PER_FLAG, 32'h0);
		$display("test polling done");
		wr(irq_pkg::OFF_PER_EN, 32'h08);
		wr(irq_pkg::OFF_PER_PRIO, 32'h00);
		wr(irq_pkg::OFF_MAIN_CTRL, 32'hC0);
		pulse_periph();
		wait_entry(irq_pkg::VEC_HIGH, 0);
		rd_chk(irq_pkg::OFF_MAIN_CTRL, 32'h40);
		wr(irq_pkg::OFF_PER_FLAG, 32'h0);
		do_ret();
		rd_chk(irq_pkg::OFF_MAIN_CTRL, 32'hC0);
		wr(irq_pkg::OFF_MAIN_CTRL, 32'h80);
		pulse_periph();
		no_entry();
		wr(irq_pkg::OFF_PER_FLAG, 32'h0);
		$display("test compat done");
		wr(irq_pkg::OFF_RESET_CTRL, 32'h80);
		wr(irq_pkg::OFF_MAIN_CTRL, 32'hC0);
		wr(irq_pkg::OFF_CORE_EN, 32'h01);
		pulse_periph();
		wait_entry(irq_pkg::VEC_LOW, 0);
		rd_chk(irq_pkg::OFF_MAIN_CTRL, 32'h80);
		@(posedge clk_sys);
		ext_pin <= 4'h1;
		wait_entry(irq_pkg::VEC_HIGH, 2 + irq_pkg::LATENCY_CYC);
		rd_chk(irq_pkg::OFF_MAIN_CTRL, 32'h00);
		rd_chk(irq_pkg::OFF_STATUS, 32'h03);
		wr(irq_pkg::OFF_CORE_FLAG, 32'h0);
		wr(irq_pkg::OFF_MAIN_CTRL, 32'hC0);
		no_entry();
		wr(irq_pkg::OFF_PER_FLAG, 32'h0);
		do_ret();
		rd_chk(irq_pkg::OFF_MAIN_CTRL, 32'hC0);
		rd_chk(irq_pkg::OFF_STATUS, 32'h02);
		do_ret();
		rd_chk(irq_pkg::OFF_STATUS, 32'h00);
		$display("test priority done");
		// both levels made pending by flag writes while globally masked
		wr(irq_pkg::OFF_MAIN_CTRL, 32'h00);
		wr(irq_pkg::OFF_CORE_FLAG, 32'h01);
		wr(irq_pkg::OFF_PER_FLAG, 32'h08);
		wr(irq_pkg::OFF_MAIN_CTRL, 32'hC0);
		wait_entry(irq_pkg::VEC_HIGH, 0);
		wr(irq_pkg::OFF_CORE_FLAG, 32'h0);
		wr(irq_pkg::OFF_PER_FLAG, 32'h0);
		do_ret();
		$display("test both_levels done");
		wr(irq_pkg::OFF_MAIN_CTRL, 32'h00);
		wr(irq_pkg::OFF_EDGE_SEL, 32'h0E);
		@(posedge clk_sys);
		ext_pin <= 4'h0;
		port_pin <= 4'h2;
		repeat (3) @(posedge clk_sys);
		rd_chk(irq_pkg::OFF_CORE_FLAG, 32'h11);
		core_sleep <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk({31'h0, wake_req}, 32'h1);
		wr(irq_pkg::OFF_CORE_FLAG, 32'h0);
		repeat (3) @(posedge clk_sys);
		chk({31'h0, wake_req}, 32'h0);
		chk(faults, 0);
		$display("test edge_wake done");
		close_out();
	end
endmodule
